// >>> hdl/window_pkg.sv
// constants for the program-space data window
package window_pkg;
    localparam int          DATA_W       = 16;        // data word width
    localparam int          OFS_W        = 15;        // offset bits taken from the effective address
    localparam int          PAGE_W       = 8;         // page select width
    localparam int          PM_AW        = PAGE_W + OFS_W;
    localparam int          PM_DW        = 24;        // program word width
    localparam int          WIN_MSB      = 15;        // effective-address bit that opens the window
    localparam int          PAGE_COUNT   = 256;
    localparam int          PAGE_WORDS   = 16384;
    localparam int          WINDOW_BYTES = 32768;
    localparam logic [15:0] WIN_BASE     = 16'h8000;
    localparam logic [7:0]  PAGE_RST     = 8'h00;
    localparam logic [1:0]  EXTRA_NONE   = 2'h0;
    localparam logic [1:0]  EXTRA_MOVE   = 2'h1;
    localparam logic [1:0]  EXTRA_OTHER  = 2'h2;
    localparam logic [1:0]  EXTRA_EDGE   = 2'h2;
    localparam logic [1:0]  CNT_ONE      = 2'h1;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH1,
        ST_FETCH2,
        ST_GATHER,
        ST_WAIT
    } state_type;
endpackage

// >>> hdl/stall_calc.sv
// extra stall cycles for a window access, by instruction kind and loop position
module stall_calc
    import window_pkg::*;
(
    input  wire logic       is_move,
    input  wire logic       in_repeat,
    input  wire logic       rpt_first,
    input  wire logic       rpt_last,
    input  wire logic       rpt_int_exit,
    input  wire logic       rpt_reentry,
    output logic [1:0]      extra
);
    // loop edges cost the full stall, the steady body costs nothing
    always_comb begin
        if (in_repeat) begin
            if (rpt_first || rpt_last || rpt_int_exit || rpt_reentry) begin
                extra = EXTRA_EDGE;
            end else begin
                extra = EXTRA_NONE;
            end
        end else if (is_move) begin
            extra = EXTRA_MOVE;
        end else begin
            extra = EXTRA_OTHER;
        end
    end
endmodule

// >>> hdl/program_space_data_window.sv
// program-space data window: redirects upper data-space reads to a flash page

// Functional notes
// - A read goes to program memory only when address bit 15 is set and the window enable bit is set.
// - The upper 32 Kbytes of data space act as an optional window onto one program-space page.
// - An 8-bit page select register picks one of 256 program pages of 16K words each.
// - The program address is the page select on top and the low 15 effective-address bits below.
// - The low 15 data-address bits map straight onto the low 15 program-address bits.
// - Only the low 16 bits of the 24-bit program word are returned; the upper byte is dropped.
// - The window is suspended while a table read or write runs and returns afterwards.
// - Outside a repeat loop a move adds one cycle and any other instruction adds two.
// - In a repeat loop the first, last, interrupt-exit and re-entry iterations add two cycles.
// - All other repeat-loop iterations add no stall.
// - Every window read makes two program fetches, which lengthens the instruction.
module program_space_data_window (
    input  wire logic                       mclk,
    input  wire logic                       nrst,
    input  wire logic                       cen,
    input  wire logic                       window_enable,
    input  wire logic                       page_wr,
    input  wire logic [window_pkg::PAGE_W-1:0] page_wdata,
    input  wire logic                       table_busy,
    input  wire logic                       req_valid,
    input  wire logic [window_pkg::DATA_W-1:0] req_addr,
    input  wire logic                       is_move,
    input  wire logic                       in_repeat,
    input  wire logic                       rpt_first,
    input  wire logic                       rpt_last,
    input  wire logic                       rpt_int_exit,
    input  wire logic                       rpt_reentry,
    input  wire logic [window_pkg::PM_DW-1:0]  pm_rdata,
    output logic                            pm_req,
    output logic [window_pkg::PM_AW-1:0]    pm_addr,
    output logic                            dm_req,
    output logic [window_pkg::DATA_W-1:0]   dm_addr,
    output logic                            busy,
    output logic                            rsp_valid,
    output logic [window_pkg::DATA_W-1:0]   rsp_data,
    output logic [window_pkg::PAGE_W-1:0]   page_sel
);
    import window_pkg::*;

    typedef struct packed {
        state_type           state;
        logic [PAGE_W-1:0]   page;
        logic [1:0]          cnt;
        logic [1:0]          extra;
        logic                pm_req;
        logic [PM_AW-1:0]    pm_addr;
        logic                dm_req;
        logic [DATA_W-1:0]   dm_addr;
        logic                busy;
        logic                rsp_valid;
        logic [DATA_W-1:0]   rsp_data;
    } regs_type;

    regs_type   st_r;
    regs_type   st_nxt;
    logic [1:0] extra;
    logic       take;
    logic       hit;

    stall_calc u_stall (
        .is_move      (is_move),
        .in_repeat    (in_repeat),
        .rpt_first    (rpt_first),
        .rpt_last     (rpt_last),
        .rpt_int_exit (rpt_int_exit),
        .rpt_reentry  (rpt_reentry),
        .extra        (extra)
    );

    // requests are only taken when idle; a busy block ignores them
    assign take = req_valid && (st_r.state == ST_IDLE);
    // window decode, table ops suspend it
    assign hit  = req_addr[WIN_MSB] && window_enable && !table_busy;

    // next-state logic
    always_comb begin
        st_nxt           = st_r;
        st_nxt.pm_req    = 1'b0;
        st_nxt.dm_req    = 1'b0;
        st_nxt.rsp_valid = 1'b0;
        if (page_wr) begin
            st_nxt.page = page_wdata;
        end
        case (st_r.state)
            ST_IDLE: begin
                if (take && hit) begin
                    st_nxt.pm_addr = {st_r.page, req_addr[OFS_W-1:0]};
                    st_nxt.pm_req  = 1'b1;
                    st_nxt.extra   = extra;
                    st_nxt.busy    = 1'b1;
                    st_nxt.state   = ST_FETCH1;
                end else if (take) begin
                    st_nxt.dm_req  = 1'b1;
                    st_nxt.dm_addr = req_addr;
                end
            end
            ST_FETCH1: begin
                st_nxt.pm_req = 1'b1;
                st_nxt.state  = ST_FETCH2;
            end
            ST_FETCH2: begin
                st_nxt.state = ST_GATHER;
            end
            ST_GATHER: begin
                st_nxt.rsp_data = pm_rdata[DATA_W-1:0];
                st_nxt.cnt      = st_r.extra;
                if (st_r.extra == EXTRA_NONE) begin
                    st_nxt.rsp_valid = 1'b1;
                    st_nxt.busy      = 1'b0;
                    st_nxt.state     = ST_IDLE;
                end else begin
                    st_nxt.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (st_r.cnt == CNT_ONE) begin
                    st_nxt.rsp_valid = 1'b1;
                    st_nxt.busy      = 1'b0;
                    st_nxt.state     = ST_IDLE;
                end else begin
                    st_nxt.cnt = st_r.cnt - CNT_ONE;
                end
            end
            default: begin
                st_nxt.busy  = 1'b0;
                st_nxt.state = ST_IDLE;
            end
        endcase
    end

    // state register, frozen while cen is low
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r           <= '0;
            st_r.state     <= ST_IDLE;
            st_r.page      <= PAGE_RST;
        end else if (cen) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign pm_req    = st_r.pm_req;
    assign pm_addr   = st_r.pm_addr;
    assign dm_req    = st_r.dm_req;
    assign dm_addr   = st_r.dm_addr;
    assign busy      = st_r.busy;
    assign rsp_valid = st_r.rsp_valid;
    assign rsp_data  = st_r.rsp_data;
    assign page_sel  = st_r.page;

    // checks other than a_freeze hold only while the clock enable runs
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst || !cen);

    property p_route_window;
        take && hit |=> pm_req && pm_addr == {$past(st_r.page), $past(req_addr[OFS_W-1:0])};
    endproperty
    a_route_window: assert property (p_route_window) else $error("window read misrouted");

    property p_route_data;
        take && !hit |=> dm_req && !pm_req && !busy;
    endproperty
    a_route_data: assert property (p_route_data) else $error("data read stalled or misrouted");

    property p_table_suspend;
        take && table_busy |=> !pm_req;
    endproperty
    a_table_suspend: assert property (p_table_suspend) else $error("window used during table op");

    property p_page_write;
        page_wr |=> page_sel == $past(page_wdata);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page select not written");

    property p_low_word;
        st_r.state == ST_GATHER |=> rsp_data == $past(pm_rdata[DATA_W-1:0]);
    endproperty
    a_low_word: assert property (p_low_word) else $error("wrong data half returned");

    property p_two_fetch;
        take && hit && extra == EXTRA_NONE |=> pm_req ##1 pm_req ##1 !pm_req && !rsp_valid ##1 rsp_valid;
    endproperty
    a_two_fetch: assert property (p_two_fetch) else $error("two fetches not made");

    property p_move_stall;
        take && hit && !in_repeat && is_move |=> !rsp_valid [*4] ##1 rsp_valid;
    endproperty
    a_move_stall: assert property (p_move_stall) else $error("move stall wrong");

    property p_edge_stall;
        take && hit && in_repeat && (rpt_first || rpt_last || rpt_int_exit || rpt_reentry)
            |=> busy [*5] ##1 rsp_valid && !busy;
    endproperty
    a_edge_stall: assert property (p_edge_stall) else $error("loop edge stall wrong");

    property p_body_nostall;
        take && hit && in_repeat && !(rpt_first || rpt_last || rpt_int_exit || rpt_reentry)
            |=> ##3 rsp_valid;
    endproperty
    a_body_nostall: assert property (p_body_nostall) else $error("loop body stalled");

    // a low clock enable must hold every bit of state, so this check stays armed then
    property p_freeze;
        disable iff (!nrst) !cen |=> $stable(st_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    c_window_read: cover property (take && hit ##4 rsp_valid);
    c_other_read:  cover property (take && hit && !in_repeat && !is_move ##6 rsp_valid);
    c_data_read:   cover property (take && !hit ##1 dm_req);
    c_table_block: cover property (take && table_busy && req_addr[WIN_MSB] && window_enable);
endmodule

// >>> tb/pm_model.sv
// program memory partner: synchronous read port of the flash
module pm_model
    import window_pkg::*;
(
    input  wire logic                          mclk,
    input  wire logic                          pm_req,
    input  wire logic [window_pkg::PM_AW-1:0]  pm_addr,
    output logic      [window_pkg::PM_DW-1:0]  pm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pm_rdata = 24'h5A5A5A;
    // upper byte uniform
    // data valid one cycle after the fetch; otherwise toggles so stale data never matches
    always @(posedge mclk) begin
        if (pm_req)
            pm_rdata <= {{8{pm_addr[0]}}, pm_addr[15:0] ^ {pm_addr[22:15], 8'h5A}};
        else
            pm_rdata <= ~pm_rdata;
    end
endmodule

// >>> tb/program_space_data_window_tb.sv
// self-checking bench for the program-space data window
module program_space_data_window_tb
    import window_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, nrst, cen, window_enable, page_wr, table_busy, req_valid, is_move, in_repeat;
    logic rpt_first, rpt_last, rpt_int_exit, rpt_reentry, pm_req, dm_req, busy, rsp_valid;
    logic [7:0]  page_wdata, page_sel, page_m;
    logic [15:0] req_addr, dm_addr, rsp_data;
    logic [22:0] pm_addr;
    logic [23:0] pm_rdata;
    logic [31:0] seed, r;
    int mismatches, checked, cycles;
    logic [15:0] exp_q[$];

    program_space_data_window dut (.mclk(mclk), .nrst(nrst), .cen(cen), .window_enable(window_enable),
        .page_wr(page_wr), .page_wdata(page_wdata), .table_busy(table_busy), .req_valid(req_valid),
        .req_addr(req_addr), .is_move(is_move), .in_repeat(in_repeat), .rpt_first(rpt_first),
        .rpt_last(rpt_last), .rpt_int_exit(rpt_int_exit), .rpt_reentry(rpt_reentry),
        .pm_rdata(pm_rdata), .pm_req(pm_req), .pm_addr(pm_addr), .dm_req(dm_req), .dm_addr(dm_addr),
        .busy(busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .page_sel(page_sel));
    pm_model mem (.mclk(mclk), .pm_req(pm_req), .pm_addr(pm_addr), .pm_rdata(pm_rdata));

    initial begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check_data(input logic [22:0] got, input logic [22:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_lat(input int got, input int exp);
        checked++;
        if (got != exp) begin
            mismatches++;
            $display("wrong value at %0t: latency %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one read; entered just after an edge with the block idle
    task automatic do_read(input logic [15:0] a, input logic [6:0] f);
        int n, ext, fetches;
        logic hit;
        logic [22:0] pa;
        hit = a[15] & f[6] & ~f[5];
        ext = f[3] ? ((|f[2:0] | f[4]) ? 2 : 0) : (f[4] ? 1 : 2);
        pa = {page_m, a[14:0]};
        {window_enable, table_busy, is_move, in_repeat, rpt_first, rpt_last, rpt_int_exit} = f;
        rpt_reentry = f[3] & f[4];
        req_addr = a;
        req_valid = 1;
        @(posedge mclk);
        #1 req_valid = 0;
        if (!hit) begin
            check_data(dm_req, 1);
            check_data(dm_addr, a);
            check_data(busy, 0);
        end else begin
            exp_q.push_back(pa[15:0] ^ {pa[22:15], 8'h5A});
            n = 1;
            fetches = 0;
            while (rsp_valid !== 1'b1 && n < 16) begin
                fetches += (pm_req === 1'b1);
                @(posedge mclk);
                #1 n++;
            end
            check_lat(fetches, 2);
            check_lat(n, 4 + ext);
            check_data(pm_addr, pa);
            check_data(rsp_data, exp_q.pop_front());
        end
        @(posedge mclk);
        #1;
    endtask

    // cycle ceiling cuts a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        {nrst, cen, window_enable, page_wr, table_busy, req_valid, is_move, in_repeat} = 8'h40;
        {rpt_first, rpt_last, rpt_int_exit, rpt_reentry} = 4'h0;
        page_wdata = 8'h00;
        req_addr = 16'h0000;
        page_m = PAGE_RST;
        seed = 32'd60;
        repeat (20) @(posedge mclk);
        #1 nrst = 1;
        check_data(page_sel, PAGE_RST);
        // each instruction kind and loop position, with reads at the window edges
        do_read(16'h8000, 7'b1000000);
        do_read(16'hFFFF, 7'b1010000);
        do_read(16'h8001, 7'b1001000);
        for (int k = 0; k < 4; k++)
            do_read(16'hC000 + 16'(k), 7'b1001000 | (k == 3 ? 7'h10 : 7'h1 << k));
        do_read(16'h7FFF, 7'b1000000);
        // random traffic with page changes, enable and table activity
        for (int i = 0; i < 60; i++) begin
            r = xs();
            if (r[31:29] == 0) begin
                page_wdata = r[7:0];
                page_wr = 1;
                @(posedge mclk);
                #1 page_wr = 0;
                page_m = r[7:0];
                check_data(page_sel, page_m);
            end
            do_read(r[15:0], {r[22] | r[23], r[24] & r[25], r[28:24]});
        end
        // a page write with the clock enable low is lost, the same write with it high lands
        cen = 0;
        page_wdata = ~page_m;
        page_wr = 1;
        @(posedge mclk);
        #1 cen = 1;
        check_data(page_sel, page_m);
        @(posedge mclk);
        #1 page_wr = 0;
        page_m = page_wdata;
        check_data(page_sel, page_m);
        // reset in mid-run returns the page to its reset value
        nrst = 0;
        @(posedge mclk);
        #1 nrst = 1;
        page_m = PAGE_RST;
        check_data(page_sel, PAGE_RST);
        do_read(16'hA5C3, 7'b1010000);
        complete_run();
    end
endmodule
